// ===== netref_mon.sv
// checks period and phase widths of one network timing reference
module netref_mon import tdm_pkg::*; #(
    parameter int unsigned NETREF_8K_P = NETREF_8K_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ref,
    output logic o_ok
);
    logic s1_r, s2_r, d_r;
    logic [15:0] per_r;
    logic [15:0] ph_r;
    logic [15:0] hi_r;
    logic rise, fall;

    function automatic logic near(input logic [15:0] x, input int unsigned t);
        return (32'(x) + NETREF_TOL_CYC >= t) && (32'(x) <= t + NETREF_TOL_CYC);
    endfunction

    assign rise = s2_r & ~d_r;
    assign fall = ~s2_r & d_r;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            // idle level of a released line, so no false edge after reset
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            d_r <= 1'b1;
        end else begin
            s1_r <= i_ref;
            s2_r <= s1_r;
            d_r <= s2_r;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            per_r <= 16'h0000;
            ph_r <= 16'h0000;
            hi_r <= 16'h0000;
        end else begin
            per_r <= rise ? 16'h0001 : (per_r == 16'hffff ? per_r : per_r + 16'h0001);
            ph_r <= (rise | fall) ? 16'h0001 : (ph_r == 16'hffff ? ph_r : ph_r + 16'h0001);
            if (fall) begin
                hi_r <= ph_r;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ok <= 1'b0;
        end else if (rise) begin
            o_ok <= (near(per_r, NETREF_8K_P) || near(per_r, NETREF_1544_CYC)
                || near(per_r, NETREF_2048_CYC))
                && (32'(hi_r) >= NETREF_MIN_CYC) && (32'(ph_r) >= NETREF_MIN_CYC);
        end else if (32'(per_r) > NETREF_8K_P + NETREF_TOL_CYC) begin
            o_ok <= 1'b0;
        end
    end
endmodule

// ===== tb_top.sv
// self-checking bench: device end and far end joined over the backplane
module tb_top import tdm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned NR_P = 400;
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b1;
    logic mmode, h110_strap, sel_b, dev_tx_en, bp_h110, bp_tx_en, ct_en_n, ct_reset_n, drove3;
    logic frame_start;
    logic [31:0] mask;
    logic [15:0] pcm_tx;
    logic [4:0] dev_tx_stream, rx_stream, bp_tx_stream;
    logic [6:0] dev_tx_slot, rx_slot, bp_tx_slot;
    logic [7:0] dev_tx_data, bp_tx_data;
    logic [1:0] netref_en;
    sclk_sel_t sclk_sel;
    netref_sel_t netref_sel;
    logic o_mmode, o_h110, o_seated, o_bus_rst, o_locked, o_rx_valid;
    logic [7:0] o_rx_data;
    logic [15:0] o_pcm_rx;
    logic [1:0] o_netref_ok;
    int err_count = 0;
    int checked = 0;
    tdm_bus_if bus ();
    tdm_dev_end #(.NETREF_8K_P(NR_P)) u_tdm_dev_end (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .bus(bus.dev), .i_mmode_strap(mmode), .i_h110_strap(h110_strap), .i_sel_b(sel_b),
        .i_stream_mask(mask), .i_tx_en(dev_tx_en), .i_tx_stream(dev_tx_stream),
        .i_tx_slot(dev_tx_slot), .i_tx_data(dev_tx_data), .i_rx_stream(rx_stream),
        .i_rx_slot(rx_slot), .i_pcm_tx(pcm_tx), .o_mmode(o_mmode), .o_h110(o_h110),
        .o_seated(o_seated), .o_bus_rst(o_bus_rst), .o_locked(o_locked),
        .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .o_pcm_rx(o_pcm_rx),
        .o_netref_ok(o_netref_ok));
    tdm_bp_end #(.NETREF_8K_P(NR_P)) u_tdm_bp_end (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .bus(bus.bp), .i_drive_a(1'b1), .i_drive_b(1'b1), .i_sclk_sel(sclk_sel),
        .i_h110(bp_h110), .i_netref_en(netref_en), .i_netref_sel(netref_sel),
        .i_ct_en_n(ct_en_n), .i_ct_reset_n(ct_reset_n), .i_tx_en(bp_tx_en),
        .i_tx_stream(bp_tx_stream), .i_tx_slot(bp_tx_slot), .i_tx_data(bp_tx_data),
        .o_frame_start(frame_start));
    tdm_bus_chk u_tdm_bus_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .dev_d_oe(bus.dev_d_oe), .bp_d_oe(bus.bp_d_oe), .tm(bus.tm), .tm_oe(bus.tm_oe));

    always #2.5 i_core_clk = ~i_core_clk;
    // sticky: device ever drove stream 3
    always @(posedge i_core_clk) begin
        if (bus.dev_d_oe[3] === 1'b1) begin
            drove3 <= 1'b1;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic reset_dut(input logic mm, input logic h1, input sclk_sel_t sel);
        @(posedge i_core_clk);
        i_rstn <= 1'b0;
        mmode <= mm;
        h110_strap <= h1;
        bp_h110 <= h1 & ~mm;
        sclk_sel <= sel;
        repeat (8) @(posedge i_core_clk);
        #1;
        check("data oe in reset", bus.dev_d_oe | bus.bp_d_oe, 32'h0);
        check("timing oe in reset", 32'(bus.tm_oe), 32'h0);
        @(posedge i_core_clk);
        i_rstn <= 1'b1;
        repeat (10) @(negedge i_core_clk);
    endtask

    task automatic t_netref();
        for (int k = 0; k < 3; k++) begin
            @(posedge i_core_clk);
            netref_en <= 2'h3;
            netref_sel <= netref_sel_t'(k);
            for (int i = 0; i < 3000 && o_netref_ok !== 2'h3; i++) @(negedge i_core_clk);
            check("netref valid", 32'(o_netref_ok), 32'h3);
            @(posedge i_core_clk);
            netref_en <= 2'h0;
            for (int i = 0; i < 1000 && o_netref_ok !== 2'h0; i++) @(negedge i_core_clk);
            check("netref lost", 32'(o_netref_ok), 32'h0);
        end
        $display("netref test done");
    endtask

    task automatic t_data();
        // first slot settings change at a frame boundary, later ones right after a receive
        for (int i = 0; i < 30000 && frame_start !== 1'b1; i++) @(negedge i_core_clk);
        @(posedge i_core_clk);
        mask <= 32'hfffffff7;
        {dev_tx_en, dev_tx_stream, dev_tx_slot, dev_tx_data} <= {1'b1, 5'h03, 7'h05, 8'ha5};
        {bp_tx_en, bp_tx_stream, bp_tx_slot, bp_tx_data} <= {1'b1, 5'h07, 7'h09, 8'h3c};
        {rx_stream, rx_slot} <= {5'h07, 7'h09};
        for (int i = 0; i < 60000 && o_rx_valid !== 1'b1; i++) @(negedge i_core_clk);
        check("rx from far end", 32'(o_rx_data), 32'h3c);
        check("locked", 32'(o_locked), 32'h1);
        check("masked stream idle", 32'(drove3), 32'h0);
        @(posedge i_core_clk);
        mask <= 32'hffffffff;
        sel_b <= 1'b1;
        {rx_stream, rx_slot} <= {5'h03, 7'h05};
        @(negedge i_core_clk);
        for (int i = 0; i < 30000 && o_rx_valid !== 1'b1; i++) @(negedge i_core_clk);
        check("rx own slot on pair b", 32'(o_rx_data), 32'ha5);
        $display("data test done");
    endtask

    task automatic t_h110();
        @(posedge i_core_clk);
        ct_en_n <= 1'b1;
        reset_dut(1'b0, 1'b1, SCLK_4M);
        check("variant", 32'({o_mmode, o_h110, o_seated}), 32'h2);
        for (int i = 0; i < 60 && bus.tm[TM_SCLKX2] !== 1'b0; i++) @(negedge i_core_clk);
        for (int i = 0; i < 60 && bus.tm[TM_SCLKX2] !== 1'b1; i++) @(negedge i_core_clk);
        check("bit clock at sample rise", 32'(bus.tm[TM_C8_A]), 32'h0);
        @(posedge i_core_clk);
        ct_en_n <= 1'b0;
        for (int i = 0; i < 20 && o_seated !== 1'b1; i++) @(negedge i_core_clk);
        check("seated", 32'(o_seated), 32'h1);
        for (int i = 0; i < 30000 && bus.dev_d_oe[3] !== 1'b1; i++) @(negedge i_core_clk);
        check("seated drive", 32'(bus.dev_d_oe[3]), 32'h1);
        @(posedge i_core_clk);
        ct_reset_n <= 1'b0;
        for (int i = 0; i < 20 && o_bus_rst !== 1'b1; i++) @(negedge i_core_clk);
        @(negedge i_core_clk);
        check("bus reset", 32'({o_bus_rst, o_locked}), 32'h2);
        check("no drive in bus reset", bus.dev_d_oe, 32'h0);
        @(posedge i_core_clk);
        ct_reset_n <= 1'b1;
        $display("second variant test done");
    endtask

    task automatic t_alt();
        @(posedge i_core_clk);
        {bp_tx_stream, bp_tx_slot, bp_tx_data} <= {5'h02, 7'h00, 8'h00};
        pcm_tx <= 16'h5a3c;
        netref_en <= 2'h3;
        reset_dut(1'b1, 1'b1, SCLK_2M);
        check("alternate straps", 32'({o_mmode, o_h110}), 32'h2);
        check("port directions", bus.dev_d_oe, 32'hffff0000);
        check("transmit ports", 32'(bus.ct_d[31:16]), 32'h5a3c);
        for (int i = 0; i < 30000 && o_pcm_rx[2] !== 1'b0; i++) @(negedge i_core_clk);
        check("receive ports", 32'(o_pcm_rx), 32'hfffb);
        repeat (3000) @(negedge i_core_clk);
        check("timing ignored", 32'({o_locked, o_netref_ok}), 32'h0);
        $display("alternate mode test done");
    endtask

    initial begin
        {mmode, h110_strap, sel_b, dev_tx_en, bp_h110, bp_tx_en} = 6'h00;
        {ct_en_n, ct_reset_n, drove3} = 3'h2;
        {mask, pcm_tx, netref_en} = 50'h0;
        {dev_tx_stream, rx_stream, bp_tx_stream} = 15'h0000;
        {dev_tx_slot, rx_slot, bp_tx_slot} = 21'h000000;
        {dev_tx_data, bp_tx_data} = 16'h0000;
        sclk_sel = SCLK_8M;
        netref_sel = NR_8K;
        // async reset taken before the first clock edge
        #1 i_rstn = 1'b0;
        reset_dut(1'b0, 1'b0, SCLK_8M);
        check("backplane straps", 32'({o_mmode, o_h110, o_seated}), 32'h1);
        t_netref();
        t_data();
        t_h110();
        t_alt();
        conclude();
    end

    initial begin
        #450000;
        err_count++;
        $display("watchdog expired");
        conclude();
    end
endmodule

// ===== tdm_bp_end.sv
// far end: clock master and one board talking on the backplane
module tdm_bp_end import tdm_pkg::*; #(
    parameter int unsigned NETREF_8K_P = NETREF_8K_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    tdm_bus_if.bp bus,
    input wire logic i_drive_a,
    input wire logic i_drive_b,
    input wire sclk_sel_t i_sclk_sel,
    input wire logic i_h110,
    input wire logic [1:0] i_netref_en,
    input wire netref_sel_t i_netref_sel,
    input wire logic i_ct_en_n,
    input wire logic i_ct_reset_n,
    input wire logic i_tx_en,
    input wire logic [4:0] i_tx_stream,
    input wire logic [6:0] i_tx_slot,
    input wire logic [7:0] i_tx_data,
    output logic o_frame_start
);
    logic [2:0] div_r;
    logic [11:0] q_r;
    logic [15:0] nr_r;
    logic [15:0] nr_per;
    logic fp_n, sclk, sclkx2;
    logic [9:0] bit_idx;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_r <= 3'h0;
            q_r <= 12'h000;
        end else if (div_r == 3'(QTR_CYC - 1)) begin
            div_r <= 3'h0;
            q_r <= q_r + 12'h001;
        end else begin
            div_r <= div_r + 3'h1;
        end
    end

    always_comb begin
        nr_per = 16'(NETREF_8K_P);
        unique case (i_netref_sel)
            NR_1544: nr_per = 16'(NETREF_1544_CYC);
            NR_2048: nr_per = 16'(NETREF_2048_CYC);
            default: nr_per = 16'(NETREF_8K_P);
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            nr_r <= 16'h0000;
        end else begin
            nr_r <= (nr_r >= nr_per - 16'h0001) ? 16'h0000 : nr_r + 16'h0001;
        end
    end

    // low across start of bit zero
    assign fp_n = !((q_r >= FP_LAST_QTR) || (q_r < FP_HALF_QTRS));
    assign bit_idx = q_r[11:2];

    always_comb begin
        sclk = ~q_r[1];
        sclkx2 = q_r[0];
        unique case (i_sclk_sel)
            SCLK_4M: begin
                sclk = ~q_r[2];
                sclkx2 = q_r[1];
            end
            SCLK_2M: begin
                sclk = ~q_r[3];
                sclkx2 = q_r[2];
            end
            default: begin
                sclk = ~q_r[1];
                sclkx2 = q_r[0];
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bus.tm_o <= '1;
            bus.tm_oe <= '0;
            bus.ct_en_n <= 1'b1;
            bus.ct_reset_n <= 1'b1;
            o_frame_start <= 1'b0;
        end else begin
            o_frame_start <= (q_r == 12'h000) && (div_r == 3'h0);
            bus.tm_o[TM_FRAME_A] <= fp_n;
            bus.tm_o[TM_FRAME_B] <= fp_n;
            bus.tm_o[TM_C8_A] <= ~q_r[1];
            bus.tm_o[TM_C8_B] <= ~q_r[1];
            bus.tm_oe[TM_FRAME_A] <= i_drive_a;
            bus.tm_oe[TM_C8_A] <= i_drive_a;
            bus.tm_oe[TM_FRAME_B] <= i_drive_b;
            bus.tm_oe[TM_C8_B] <= i_drive_b;
            bus.tm_o[TM_FR_COMP] <= fp_n;
            bus.tm_o[TM_SCLK] <= sclk;
            bus.tm_o[TM_SCLKX2] <= i_h110 ? q_r[1] : sclkx2;
            bus.tm_oe[TM_FR_COMP] <= i_drive_a | i_drive_b;
            bus.tm_oe[TM_SCLK] <= i_drive_a | i_drive_b;
            bus.tm_oe[TM_SCLKX2] <= i_drive_a | i_drive_b;
            bus.tm_o[TM_NETREF1] <= nr_r < {1'b0, nr_per[15:1]};
            bus.tm_o[TM_NETREF2] <= nr_r < {1'b0, nr_per[15:1]};
            bus.tm_oe[TM_NETREF1] <= i_netref_en[0];
            bus.tm_oe[TM_NETREF2] <= i_netref_en[1];
            bus.ct_en_n <= i_ct_en_n;
            bus.ct_reset_n <= i_ct_reset_n;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bus.bp_d_o <= '1;
            bus.bp_d_oe <= '0;
        end else begin
            bus.bp_d_oe <= '0;
            if (i_tx_en && bit_idx[9:3] == i_tx_slot) begin
                bus.bp_d_oe[i_tx_stream] <= 1'b1;
                bus.bp_d_o[i_tx_stream] <= i_tx_data[~bit_idx[2:0]];
            end
        end
    end
endmodule

// ===== tdm_bus_chk.sv
// concurrent checks on the backplane wires between the two ends
module tdm_bus_chk import tdm_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic [STREAMS-1:0] dev_d_oe,
    input wire logic [STREAMS-1:0] bp_d_oe,
    input wire logic [TM_W-1:0] tm,
    input wire logic [TM_W-1:0] tm_oe
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    logic frame_q_r;
    logic [1:0] falls_r;
    logic [15:0] low_cnt_r;
    logic [15:0] per_cnt_r;
    logic frame_fell;
    assign frame_fell = frame_q_r & ~tm[TM_FRAME_A];
    // frame pulse width and period counters; the pulse cut short by reset is skipped
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            frame_q_r <= 1'b1;
            falls_r <= 2'h0;
            low_cnt_r <= 16'h0000;
            per_cnt_r <= 16'h0000;
        end else begin
            frame_q_r <= tm[TM_FRAME_A];
            low_cnt_r <= tm[TM_FRAME_A] ? 16'h0000 : low_cnt_r + 16'h0001;
            per_cnt_r <= frame_fell ? 16'h0001 : per_cnt_r + 16'h0001;
            if (frame_fell && falls_r != 2'h3) begin
                falls_r <= falls_r + 2'h1;
            end
        end
    end
    reset_hiz_a: assert property (disable iff (1'b0)
        !i_rstn |-> dev_d_oe == '0 && bp_d_oe == '0 && tm_oe == '0)
        else $error("bus driven during reset");
    frame_width_a: assert property ($rose(tm[TM_FRAME_A]) && falls_r >= 2'h2
        |-> low_cnt_r == 16'(BIT_CYC)) else $error("frame pulse width off");
    frame_period_a: assert property (frame_fell && falls_r >= 2'h2
        |-> per_cnt_r == 16'(FRAME_QTRS * QTR_CYC)) else $error("frame period off");
    bit_clock_a: assert property ($rose(tm[TM_C8_A])
        |-> ##12 $fell(tm[TM_C8_A]) ##12 $rose(tm[TM_C8_A])) else $error("bit clock off");
    redundant_pair_a: assert property (tm[TM_FRAME_B] == tm[TM_FRAME_A]
        && tm[TM_C8_B] == tm[TM_C8_A]) else $error("redundant pair differs");
    comp_pulse_a: assert property (tm[TM_FR_COMP] == tm[TM_FRAME_A])
        else $error("compatibility pulse differs");
    sclk_bit_edge_a: assert property ($rose(tm[TM_SCLK]) |-> $rose(tm[TM_C8_A]))
        else $error("legacy clock rise off bit start");
    sclk_on_x2_a: assert property ($changed(tm[TM_SCLK]) |-> $fell(tm[TM_SCLKX2]))
        else $error("legacy clock moved off double clock fall");
    one_driver_a: assert property ((dev_d_oe & bp_d_oe) == '0)
        else $error("two drivers on a data line");
    drive_align_a: assert property ($rose(dev_d_oe[3])
        |-> $past(tm[TM_C8_A], 3) && !$past(tm[TM_C8_A], 4)) else $error("drive off bit");
endmodule

// ===== tdm_bus_if.sv
// backplane wires with the pull-up resolution of every shared line
interface tdm_bus_if;
    import tdm_pkg::*;
    logic [STREAMS-1:0] dev_d_o;
    logic [STREAMS-1:0] dev_d_oe;
    logic [STREAMS-1:0] bp_d_o;
    logic [STREAMS-1:0] bp_d_oe;
    logic [STREAMS-1:0] ct_d;
    logic [TM_W-1:0] tm_o;
    logic [TM_W-1:0] tm_oe;
    logic [TM_W-1:0] tm;
    logic ct_en_n;
    logic ct_reset_n;
    // undriven lines float high
    assign tm = (tm_o & tm_oe) | ~tm_oe;
    assign ct_d = (dev_d_o & dev_d_oe) | (bp_d_o & bp_d_oe & ~dev_d_oe) | ~(dev_d_oe | bp_d_oe);
    modport dev (output dev_d_o, output dev_d_oe, input ct_d, input tm,
        input ct_en_n, input ct_reset_n);
    modport bp (output bp_d_o, output bp_d_oe, output tm_o, output tm_oe,
        output ct_en_n, output ct_reset_n, input ct_d);
endinterface

// ===== tdm_dev_end.sv
// device end: backplane timing follower, slot access and alternate port mode
module tdm_dev_end import tdm_pkg::*; #(
    parameter int unsigned NETREF_8K_P = NETREF_8K_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    tdm_bus_if.dev bus,
    input wire logic i_mmode_strap,
    input wire logic i_h110_strap,
    input wire logic i_sel_b,
    input wire logic [STREAMS-1:0] i_stream_mask,
    input wire logic i_tx_en,
    input wire logic [4:0] i_tx_stream,
    input wire logic [6:0] i_tx_slot,
    input wire logic [7:0] i_tx_data,
    input wire logic [4:0] i_rx_stream,
    input wire logic [6:0] i_rx_slot,
    input wire logic [HALF_STREAMS-1:0] i_pcm_tx,
    output logic o_mmode,
    output logic o_h110,
    output logic o_seated,
    output logic o_bus_rst,
    output logic o_locked,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic [HALF_STREAMS-1:0] o_pcm_rx,
    output logic [1:0] o_netref_ok
);
    dev_state_t state_r;
    logic [1:0] settle_r;
    logic [TM_W-1:0] tm_s1_r, tm_s2_r;
    logic [STREAMS-1:0] d_s1_r, d_s2_r;
    logic [3:0] pin_s1_r, pin_s2_r;
    logic c8, fr_n, c8_d_r, rise, fall, hbus, run, seated;
    logic [9:0] bit_r;
    logic [9:0] bit_nxt;
    logic lock_nxt;
    logic [6:0] shift_r;
    logic [1:0] nr_ok;

    // pins from the backplane and straps
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tm_s1_r <= '1;
            tm_s2_r <= '1;
            d_s1_r <= '1;
            d_s2_r <= '1;
            pin_s1_r <= 4'h3;
            pin_s2_r <= 4'h3;
        end else begin
            tm_s1_r <= bus.tm;
            tm_s2_r <= tm_s1_r;
            d_s1_r <= bus.ct_d;
            d_s2_r <= d_s1_r;
            pin_s1_r <= {i_h110_strap, i_mmode_strap, bus.ct_reset_n, bus.ct_en_n};
            pin_s2_r <= pin_s1_r;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= ST_STRAP;
            settle_r <= 2'h0;
            o_mmode <= 1'b0;
            o_h110 <= 1'b0;
        end else begin
            unique case (state_r)
                ST_STRAP: begin
                    settle_r <= settle_r + 2'h1;
                    if (settle_r == STRAP_SETTLE) begin
                        o_mmode <= pin_s2_r[2];
                        o_h110 <= pin_s2_r[3] & ~pin_s2_r[2];
                        state_r <= pin_s2_r[2] ? ST_PCM : ST_HBUS;
                    end
                end
                ST_HBUS: state_r <= ST_HBUS;
                ST_PCM: state_r <= ST_PCM;
                default: state_r <= ST_STRAP;
            endcase
        end
    end

    assign hbus = state_r == ST_HBUS;
    // seated when low in second variant
    assign seated = !o_h110 || !pin_s2_r[0];
    // timing only used in backplane mode
    assign run = hbus && !o_bus_rst;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_bus_rst <= 1'b0;
            o_seated <= 1'b0;
        end else begin
            o_bus_rst <= o_h110 && !pin_s2_r[1];
            o_seated <= seated;
        end
    end

    assign c8 = i_sel_b ? tm_s2_r[TM_C8_B] : tm_s2_r[TM_C8_A];
    assign fr_n = i_sel_b ? tm_s2_r[TM_FRAME_B] : tm_s2_r[TM_FRAME_A];
    assign rise = c8 & ~c8_d_r;
    assign fall = ~c8 & c8_d_r;
    assign bit_nxt = fr_n ? bit_r + 10'h001 : 10'h000;
    assign lock_nxt = o_locked | ~fr_n;

    // bit count, frame pulse marks bit zero
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            c8_d_r <= 1'b1;
            bit_r <= 10'h000;
            o_locked <= 1'b0;
        end else begin
            c8_d_r <= c8;
            if (!run) begin
                bit_r <= 10'h000;
                o_locked <= 1'b0;
            end else if (rise) begin
                bit_r <= bit_nxt;
                o_locked <= lock_nxt;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bus.dev_d_o <= '1;
            bus.dev_d_oe <= '0;
        end else if (state_r == ST_PCM) begin
            bus.dev_d_oe <= {{HALF_STREAMS{1'b1}}, {HALF_STREAMS{1'b0}}};
            bus.dev_d_o <= {i_pcm_tx, {HALF_STREAMS{1'b1}}};
        end else if (!run || !seated) begin
            bus.dev_d_oe <= '0;
        end else if (rise) begin
            bus.dev_d_oe <= '0;
            // own slot on an attached stream
            if (lock_nxt && i_tx_en && i_stream_mask[i_tx_stream]
                && bit_nxt[9:3] == i_tx_slot) begin
                bus.dev_d_oe[i_tx_stream] <= 1'b1;
                bus.dev_d_o[i_tx_stream] <= i_tx_data[~bit_nxt[2:0]];
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pcm_rx <= '0;
        end else begin
            o_pcm_rx <= (state_r == ST_PCM) ? d_s2_r[HALF_STREAMS-1:0] : '0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            shift_r <= 7'h00;
            o_rx_data <= 8'h00;
            o_rx_valid <= 1'b0;
        end else begin
            o_rx_valid <= 1'b0;
            if (run && fall && o_locked && i_stream_mask[i_rx_stream]
                && bit_r[9:3] == i_rx_slot) begin
                shift_r <= {shift_r[5:0], d_s2_r[i_rx_stream]};
                if (bit_r[2:0] == 3'h7) begin
                    o_rx_data <= {shift_r, d_s2_r[i_rx_stream]};
                    o_rx_valid <= 1'b1;
                end
            end
        end
    end

    // references checked on their own, no frame phase
    netref_mon #(.NETREF_8K_P(NETREF_8K_P)) u_nr1 (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_ref(bus.tm[TM_NETREF1]),
        .o_ok(nr_ok[0])
    );
    netref_mon #(.NETREF_8K_P(NETREF_8K_P)) u_nr2 (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_ref(bus.tm[TM_NETREF2]),
        .o_ok(nr_ok[1])
    );

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_netref_ok <= 2'h0;
        end else begin
            o_netref_ok <= nr_ok & {2{hbus}};
        end
    end
endmodule

// ===== tdm_pkg.sv
// constants and types shared by both ends of the telephony backplane link
// Summary of operation
// - master frame sync: low pulse, one bit, per frame
// - primary master bit clock 8.192 MHz, half duty; here 24 core clocks per bit, 8.333 MHz
// - redundant frame and bit clock, same timing
// - drive data line only in own slots
// - 128 slots per frame at bit clock
// - 32 streams, board may use a subset
// - alternate mode: lower 16 lines are inputs
// - alternate mode: upper 16 lines are outputs
// - timing pins ignored in alternate mode
// - network reference 8 kHz, 1.544 MHz or 2.048 MHz, phases at least 90 ns
// - one driver per network reference line
// - network reference has no phase to frame
// - low seated input means rear connector in
// - low bus reset input resets bus logic
// - compatibility frame pulse like frame sync
// - legacy clock selectable, rising edge starts bit
// - double clock twice legacy, legacy on falls
// - second variant: mid-bit sampling clock instead
// - strap selects backplane or alternate mode
// - strap selects variant, low in alternate mode
package tdm_pkg;
    localparam int unsigned CORE_CLK_KHZ = 200000;
    localparam int unsigned CORE_PERIOD_PS = 5000;
    localparam int unsigned BIT_CLK_KHZ = 8192;
    localparam int unsigned BIT_CYC = CORE_CLK_KHZ / BIT_CLK_KHZ;
    localparam int unsigned QTR_CYC = BIT_CYC / 4;
    localparam int unsigned STREAMS = 32;
    localparam int unsigned HALF_STREAMS = STREAMS / 2;
    localparam int unsigned SLOTS = 128;
    localparam int unsigned FRAME_QTRS = SLOTS * 8 * 4;
    localparam int unsigned FRAME_PULSE_NS = 122;
    localparam logic [11:0] FP_HALF_QTRS = 12'h002;
    localparam logic [11:0] FP_LAST_QTR = 12'hffe;
    localparam int unsigned NETREF_8K_NS = 125000;
    localparam int unsigned NETREF_1544_NS = 647;
    localparam int unsigned NETREF_2048_NS = 488;
    localparam int unsigned NETREF_MIN_PHASE_NS = 90;
    localparam int unsigned NETREF_8K_CYC = NETREF_8K_NS * 1000 / CORE_PERIOD_PS;
    localparam int unsigned NETREF_1544_CYC = NETREF_1544_NS * 1000 / CORE_PERIOD_PS;
    localparam int unsigned NETREF_2048_CYC = NETREF_2048_NS * 1000 / CORE_PERIOD_PS;
    localparam int unsigned NETREF_MIN_CYC =
        (NETREF_MIN_PHASE_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
    localparam int unsigned NETREF_TOL_CYC = 2;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // timing pin positions in the bundled timing vector
    localparam int unsigned TM_FRAME_A = 0;
    localparam int unsigned TM_C8_A = 1;
    localparam int unsigned TM_FRAME_B = 2;
    localparam int unsigned TM_C8_B = 3;
    localparam int unsigned TM_FR_COMP = 4;
    localparam int unsigned TM_SCLK = 5;
    localparam int unsigned TM_SCLKX2 = 6;
    localparam int unsigned TM_NETREF1 = 7;
    localparam int unsigned TM_NETREF2 = 8;
    localparam int unsigned TM_W = 9;
    typedef enum logic [1:0] {SCLK_8M, SCLK_4M, SCLK_2M} sclk_sel_t;
    typedef enum logic [1:0] {NR_8K, NR_1544, NR_2048} netref_sel_t;
    typedef enum logic [1:0] {ST_STRAP, ST_HBUS, ST_PCM} dev_state_t;
endpackage
